// ---- common/dsc_defines.vh ----
// Field positions, addresses and codes for the synthesizer control words
`ifndef DSC_DEFINES_VH
`define DSC_DEFINES_VH

`define DSC_SHIFT_W       22
`define DSC_DATA_W        20
`define DSC_ADDR_SYN2_REF 2'h0
`define DSC_ADDR_SYN2_FB  2'h1
`define DSC_ADDR_SYN1_REF 2'h2
`define DSC_ADDR_SYN1_FB  2'h3
`define DSC_WORD_RESET    20'h00000

// Word bit positions, data-field indices (word bit minus 2)
`define DSC_REF_DIV_LSB   0
`define DSC_REF_DIV_MSB   14
`define DSC_REF_POL_BIT   15
`define DSC_REF_GAIN_BIT  16
`define DSC_REF_HIZ_BIT   17
`define DSC_REF_SELA_BIT  18
`define DSC_REF_SELB_BIT  19
`define DSC_FB_SWAL_LSB   0
`define DSC_FB_SWAL_MSB   6
`define DSC_FB_BIN_LSB    7
`define DSC_FB_BIN_MSB    17
`define DSC_FB_PRE_BIT    18
`define DSC_FB_SYNTH_POWERDOWN_BIT   19

`define DSC_REF_DIV_MIN   15'h0003
`define DSC_FB_BIN_MIN    11'h003

// Operating modes from high-impedance and powerdown bits
`define DSC_MODE_ACTIVE   2'h0
`define DSC_MODE_HIZ      2'h1
`define DSC_MODE_SYNC_PD  2'h2
`define DSC_MODE_ASYNC_PD 2'h3

// Output select codes
`define DSC_SEL_LOW       4'h0
`define DSC_SEL_REF2      4'h1
`define DSC_SEL_REF1      4'h2
`define DSC_SEL_FAST      4'h3
`define DSC_SEL_LD2       4'h4
`define DSC_SEL_FB2       4'h5
`define DSC_SEL_FB1       4'h6
`define DSC_SEL_RST2      4'h7
`define DSC_SEL_LD1       4'h8
`define DSC_SEL_RST1      4'hb
`define DSC_SEL_LDALL     4'hc
`define DSC_SEL_RSTALL    4'hf

`endif

// ---- rtl/dsc_control_words.v ----
// Serial control-word loader and field decoder for a dual synthesizer
`timescale 1ns/10ps
`default_nettype none
`include "dsc_defines.vh"

module dsc_control_words (
  input  wire        mclk,              // System clock, 200 MHz
  input  wire        reset,             // Synchronous reset, active high
  input  wire        ser_clk,           // Serial clock pin
  input  wire        ser_data,          // Serial data pin
  input  wire        load_strobe,       // Load strobe pin
  input  wire        ref1_div_out,      // First reference divider output
  input  wire        ref2_div_out,      // Second reference divider output
  input  wire        fb1_div_out,       // First feedback divider output
  input  wire        fb2_div_out,       // Second feedback divider output
  input  wire        lock1_detect,      // First analog lock detect
  input  wire        lock2_detect,      // Second analog lock detect
  input  wire        fast_acquire,      // First loop in fast acquisition
  input  wire        pump1_pulse_done,  // First pump pulse just ended
  input  wire        pump2_pulse_done,  // Second pump pulse just ended
  output reg  [14:0] reference_divide_count1, // First reference ratio
  output reg  [14:0] reference_divide_count2, // Second reference ratio
  output reg  [6:0]  swallow_count1,    // First swallow count
  output reg  [6:0]  swallow_count2,    // Second swallow count
  output reg  [10:0] binary_feedback_count1, // First binary count
  output reg  [10:0] binary_feedback_count2, // Second binary count
  output reg         detector_polarity1, // First polarity, 1 positive
  output reg         detector_polarity2, // Second polarity, 1 positive
  output reg         pump_current_gain1, // First gain, 1 high
  output reg         pump_current_gain2, // Second gain, 1 high
  output reg         pump_hiz_select1,  // First pump high impedance
  output reg         pump_hiz_select2,  // Second pump high impedance
  output reg         prescaler_sel1,    // First prescaler, 1 is 128/129
  output reg         prescaler_sel2,    // Second prescaler, 1 is 128/129
  output reg         synth_powerdown1,  // First powerdown bit
  output reg         synth_powerdown2,  // Second powerdown bit
  output reg  [1:0]  op_mode1,          // First operating mode
  output reg  [1:0]  op_mode2,          // Second operating mode
  output reg         synth_off1,        // First synthesizer powered down
  output reg         synth_off2,        // Second synthesizer powered down
  output reg  [3:0]  multifunction_out_select, // Output select code
  output reg         counter_hold1,     // Hold first dividers at load
  output reg         counter_hold2,     // Hold second dividers at load
  output reg         mf_out,            // Multi-function pin output
  output reg         mf_oe,             // Multi-function pin enable
  output reg         ratio_error        // A loaded ratio is below minimum
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [1:0] sclk_sync_q;
  reg [1:0] sdat_sync_q;
  reg [1:0] le_sync_q;
  reg       sclk_prev_q;
  reg       le_prev_q;

  always @(posedge mclk) begin
    if (reset) begin
      sclk_sync_q <= 2'h0;
      sdat_sync_q <= 2'h0;
      le_sync_q   <= 2'h0;
      sclk_prev_q <= 1'b0;
      le_prev_q   <= 1'b0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[0], ser_clk};
      sdat_sync_q <= {sdat_sync_q[0], ser_data};
      le_sync_q   <= {le_sync_q[0], load_strobe};
      sclk_prev_q <= sclk_sync_q[1];
      le_prev_q   <= le_sync_q[1];
    end
  end

  wire sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;
  wire le_rise   = le_sync_q[1] & ~le_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // Status input synchronisers
  // Divider and lock levels run on other clocks; two flops each
  wire ref1_s;
  wire ref2_s;
  wire fb1_s;
  wire fb2_s;
  wire lock1_s;
  wire lock2_s;
  wire fast_s;

  dsc_sync2 ref1_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   (ref1_div_out),
    .dout  (ref1_s)
  );

  dsc_sync2 ref2_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   (ref2_div_out),
    .dout  (ref2_s)
  );

  dsc_sync2 fb1_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   (fb1_div_out),
    .dout  (fb1_s)
  );

  dsc_sync2 fb2_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   (fb2_div_out),
    .dout  (fb2_s)
  );

  dsc_sync2 lock1_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   (lock1_detect),
    .dout  (lock1_s)
  );

  dsc_sync2 lock2_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   (lock2_detect),
    .dout  (lock2_s)
  );

  dsc_sync2 fast_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   (fast_acquire),
    .dout  (fast_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Shift register and word latch
  reg [21:0] shift_q;
  reg [19:0] s2_ref_q;
  reg [19:0] s2_fb_q;
  reg [19:0] s1_ref_q;
  reg [19:0] s1_fb_q;

  wire [1:0]  addr = shift_q[1:0];
  wire [19:0] data = shift_q[21:2];

  always @(posedge mclk) begin
    if (reset) begin
      shift_q  <= 22'h000000;
      s2_ref_q <= `DSC_WORD_RESET;
      s2_fb_q  <= `DSC_WORD_RESET;
      s1_ref_q <= `DSC_WORD_RESET;
      s1_fb_q  <= `DSC_WORD_RESET;
    end else begin
      if (sclk_rise)
        shift_q <= {shift_q[20:0], sdat_sync_q[1]};
      if (le_rise) begin
        case (addr)
          `DSC_ADDR_SYN2_REF: s2_ref_q <= data;
          `DSC_ADDR_SYN2_FB:  s2_fb_q  <= data;
          `DSC_ADDR_SYN1_REF: s1_ref_q <= data;
          `DSC_ADDR_SYN1_FB:  s1_fb_q  <= data;
          default:            s1_fb_q  <= s1_fb_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field decode
  wire [3:0] sel_d = {s1_ref_q[`DSC_REF_SELA_BIT],
                      s2_ref_q[`DSC_REF_SELA_BIT],
                      s1_ref_q[`DSC_REF_SELB_BIT],
                      s2_ref_q[`DSC_REF_SELB_BIT]};
  reg        sync_pd1_q;
  reg        sync_pd2_q;

  // Prohibited ratios still load; the flag shows the host its mistake
  wire ref1_low = s1_ref_q[`DSC_REF_DIV_MSB:`DSC_REF_DIV_LSB] <
                  `DSC_REF_DIV_MIN;
  wire ref2_low = s2_ref_q[`DSC_REF_DIV_MSB:`DSC_REF_DIV_LSB] <
                  `DSC_REF_DIV_MIN;
  wire bin1_low = s1_fb_q[`DSC_FB_BIN_MSB:`DSC_FB_BIN_LSB] <
                  `DSC_FB_BIN_MIN;
  wire bin2_low = s2_fb_q[`DSC_FB_BIN_MSB:`DSC_FB_BIN_LSB] <
                  `DSC_FB_BIN_MIN;

  always @(posedge mclk) begin
    if (reset) begin
      reference_divide_count1 <= 15'h0000;
      reference_divide_count2 <= 15'h0000;
      swallow_count1          <= 7'h00;
      swallow_count2          <= 7'h00;
      binary_feedback_count1  <= 11'h000;
      binary_feedback_count2  <= 11'h000;
      detector_polarity1      <= 1'b0;
      detector_polarity2      <= 1'b0;
      pump_current_gain1      <= 1'b0;
      pump_current_gain2      <= 1'b0;
      pump_hiz_select1        <= 1'b0;
      pump_hiz_select2        <= 1'b0;
      prescaler_sel1          <= 1'b0;
      prescaler_sel2          <= 1'b0;
      synth_powerdown1        <= 1'b0;
      synth_powerdown2        <= 1'b0;
      op_mode1                <= `DSC_MODE_ACTIVE;
      op_mode2                <= `DSC_MODE_ACTIVE;
      multifunction_out_select <= `DSC_SEL_LOW;
      ratio_error             <= 1'b0;
    end else begin
      reference_divide_count1 <=
        s1_ref_q[`DSC_REF_DIV_MSB:`DSC_REF_DIV_LSB];
      reference_divide_count2 <=
        s2_ref_q[`DSC_REF_DIV_MSB:`DSC_REF_DIV_LSB];
      detector_polarity1 <= s1_ref_q[`DSC_REF_POL_BIT];
      detector_polarity2 <= s2_ref_q[`DSC_REF_POL_BIT];
      pump_current_gain1 <= s1_ref_q[`DSC_REF_GAIN_BIT];
      pump_current_gain2 <= s2_ref_q[`DSC_REF_GAIN_BIT];
      pump_hiz_select1   <= s1_ref_q[`DSC_REF_HIZ_BIT];
      pump_hiz_select2   <= s2_ref_q[`DSC_REF_HIZ_BIT];
      swallow_count1 <= s1_fb_q[`DSC_FB_SWAL_MSB:`DSC_FB_SWAL_LSB];
      swallow_count2 <= s2_fb_q[`DSC_FB_SWAL_MSB:`DSC_FB_SWAL_LSB];
      binary_feedback_count1 <=
        s1_fb_q[`DSC_FB_BIN_MSB:`DSC_FB_BIN_LSB];
      binary_feedback_count2 <=
        s2_fb_q[`DSC_FB_BIN_MSB:`DSC_FB_BIN_LSB];
      prescaler_sel1   <= s1_fb_q[`DSC_FB_PRE_BIT];
      prescaler_sel2   <= s2_fb_q[`DSC_FB_PRE_BIT];
      synth_powerdown1 <= s1_fb_q[`DSC_FB_SYNTH_POWERDOWN_BIT];
      synth_powerdown2 <= s2_fb_q[`DSC_FB_SYNTH_POWERDOWN_BIT];
      op_mode1 <= {s1_fb_q[`DSC_FB_SYNTH_POWERDOWN_BIT],
                   s1_ref_q[`DSC_REF_HIZ_BIT]};
      op_mode2 <= {s2_fb_q[`DSC_FB_SYNTH_POWERDOWN_BIT],
                   s2_ref_q[`DSC_REF_HIZ_BIT]};
      multifunction_out_select <= sel_d;
      ratio_error <= ref1_low | ref2_low | bin1_low | bin2_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Powerdown sequencing
  always @(posedge mclk) begin
    if (reset) begin
      sync_pd1_q <= 1'b0;
      sync_pd2_q <= 1'b0;
      synth_off1 <= 1'b0;
      synth_off2 <= 1'b0;
    end else begin
      // Sync powerdown waits for the end of a pump pulse
      case (op_mode1)
        `DSC_MODE_ASYNC_PD: sync_pd1_q <= 1'b1;
        `DSC_MODE_SYNC_PD:  sync_pd1_q <= sync_pd1_q | pump1_pulse_done;
        default:            sync_pd1_q <= 1'b0;
      endcase
      case (op_mode2)
        `DSC_MODE_ASYNC_PD: sync_pd2_q <= 1'b1;
        `DSC_MODE_SYNC_PD:  sync_pd2_q <= sync_pd2_q | pump2_pulse_done;
        default:            sync_pd2_q <= 1'b0;
      endcase
      synth_off1 <= (op_mode1 == `DSC_MODE_ASYNC_PD) |
                    ((op_mode1 == `DSC_MODE_SYNC_PD) &
                     (sync_pd1_q | pump1_pulse_done));
      synth_off2 <= (op_mode2 == `DSC_MODE_ASYNC_PD) |
                    ((op_mode2 == `DSC_MODE_SYNC_PD) &
                     (sync_pd2_q | pump2_pulse_done));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Multi-function pin
  always @(posedge mclk) begin
    if (reset) begin
      mf_out        <= 1'b0;
      mf_oe         <= 1'b1;
      counter_hold1 <= 1'b0;
      counter_hold2 <= 1'b0;
    end else begin
      // Both dividers of a loop share one hold so they restart aligned
      counter_hold1 <= (sel_d == `DSC_SEL_RST1) |
                       (sel_d == `DSC_SEL_RSTALL);
      counter_hold2 <= (sel_d == `DSC_SEL_RST2) |
                       (sel_d == `DSC_SEL_RSTALL);
      mf_oe <= 1'b1;
      case (sel_d[2:0])
        3'h1: mf_out <= ref2_s;
        3'h2: mf_out <= ref1_s;
        3'h5: mf_out <= fb2_s;
        3'h6: mf_out <= fb1_s;
        3'h3: begin
          if (sel_d[3]) begin
            mf_out <= 1'b0;
          end else begin
            // Open drain pulls low while fast acquisition is active
            mf_out <= 1'b0;
            mf_oe  <= fast_s;
          end
        end
        3'h7: mf_out <= 1'b0;
        3'h4: begin
          case (sel_d[3:2])
            2'h1:    mf_out <= lock2_s;
            2'h2:    mf_out <= lock1_s;
            2'h3:    mf_out <= lock1_s & lock2_s;
            default: mf_out <= 1'b0;
          endcase
        end
        default: begin
          // 1000 is lock detect of the first loop, 0000 drives low
          mf_out <= sel_d[3] ? lock1_s : 1'b0;
        end
      endcase
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser for a level from another clock
module dsc_sync2 (
  input  wire mclk,  // System clock
  input  wire reset, // Synchronous reset, active high
  input  wire din,   // Level from another clock domain
  output wire dout   // Level safe to read in this domain
);

  reg [1:0] sync_q;

  always @(posedge mclk) begin
    if (reset) begin
      sync_q <= 2'h0;
    end else begin
      sync_q <= {sync_q[0], din};
    end
  end

  assign dout = sync_q[1];

endmodule
`default_nettype wire

// ---- sim/dsc_control_props.sv ----
// Checker for the decoded control outputs
`timescale 1ns/10ps
`default_nettype none
module dsc_control_props (
  input wire logic       mclk,                     // Clock
  input wire logic       reset,                    // Sync reset
  input wire logic [3:0] multifunction_out_select, // Select code
  input wire logic       counter_hold1,            // Hold first
  input wire logic       counter_hold2,            // Hold second
  input wire logic       mf_out,                   // Pin data
  input wire logic       mf_oe,                    // Pin enable
  input wire logic [1:0] op_mode1,                 // First mode
  input wire logic [1:0] op_mode2,                 // Second mode
  input wire logic       synth_powerdown1,         // First powerdown
  input wire logic       pump_hiz_select1,         // First hiz
  input wire logic       synth_off1,               // First off
  input wire logic       synth_off2,               // Second off
  input wire logic       pump2_pulse_done          // Second pulse end
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  wire [3:0] s = multifunction_out_select;
  ////////////////////////////////////////////////////////////////////////
  hold_first_a: assert property (
    $stable(s)[*2] |-> counter_hold1 == (s == 4'hb || s == 4'hf))
    else $error("first hold wrong");
  hold_second_a: assert property (
    $stable(s)[*2] |-> counter_hold2 == (s == 4'h7 || s == 4'hf))
    else $error("second hold wrong");
  pin_drive_a: assert property (
    ($stable(s)[*2] ##0 s != 4'h3) |-> mf_oe)
    else $error("pin not driven");
  fast_low_a: assert property (
    ($stable(s)[*2] ##0 s == 4'h3) |-> !mf_out)
    else $error("open drain data high");
  reset_low_a: assert property (
    ($stable(s)[*2] ##0 (s == 4'h7 || s[1:0] == 2'h3 && s[3])) |-> !mf_out)
    else $error("pin high in counter reset");
  mode_pair_a: assert property (
    $stable({synth_powerdown1, pump_hiz_select1})[*3] |->
      op_mode1 == {synth_powerdown1, pump_hiz_select1})
    else $error("mode not from bits");
  async_off_a: assert property (
    (op_mode1 == 2'h3)[*3] |-> synth_off1)
    else $error("async powerdown late");
  active_on_a: assert property (
    (op_mode2[1] == 1'b0)[*3] |-> !synth_off2)
    else $error("active synth off");
  sync_wait_a: assert property (
    (op_mode2 == 2'h2 && $stable(op_mode2) && !synth_off2 &&
     !pump2_pulse_done && !$past(pump2_pulse_done)) |=> !synth_off2)
    else $error("sync powerdown early");
  fast_c: cover property (s == 4'h3);
  hold_all_c: cover property (counter_hold1 && counter_hold2);
  sync_off_c: cover property (op_mode2 == 2'h2 && synth_off2);
endmodule
bind dsc_control_words dsc_control_props chk (
  .mclk(mclk), .reset(reset), .mf_out(mf_out), .mf_oe(mf_oe),
  .multifunction_out_select(multifunction_out_select),
  .counter_hold1(counter_hold1), .counter_hold2(counter_hold2),
  .op_mode1(op_mode1), .op_mode2(op_mode2),
  .synth_powerdown1(synth_powerdown1), .pump_hiz_select1(pump_hiz_select1),
  .synth_off1(synth_off1), .synth_off2(synth_off2),
  .pump2_pulse_done(pump2_pulse_done));
`default_nettype wire

// ---- sim/dsc_host_model.sv ----
// Host controller model for the three-wire load interface
`timescale 1ns/10ps
`default_nettype none
module dsc_host_model (
  output logic ser_clk,     // Serial clock, still between frames
  output logic ser_data,    // Serial data
  output logic load_strobe  // Load strobe
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_strobe = 1'b0;
  end
  // Word is {data, addr}, sent MSB first at 48 ns per bit
  task automatic send(input logic [21:0] w, input logic strobe);
    integer i;
    for (i = 21; i >= 0; i--) begin
      ser_data = w[i];
      #24 ser_clk = 1'b1;
      #24 ser_clk = 1'b0;
    end
    ser_data = ~w[0];
    #24 load_strobe = strobe;
    #48 load_strobe = 1'b0;
    #24;
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Testbench for the control-word decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [6:0] aux = 7'h00; // {ref1,ref2,fb1,fb2,lock1,lock2,fast}
  logic pd1 = 1'b0, pd2 = 1'b0;
  wire sck, sda, sle, pol1, pol2, gn1, gn2, hz1, hz2, ps1, ps2, pw1, pw2;
  wire off1, off2, h1, h2, mfo, mfe, rerr;
  wire [14:0] rc1, rc2;
  wire [10:0] bc1, bc2;
  wire [6:0] sw1, sw2;
  wire [1:0] om1, om2;
  wire [3:0] sel;
  integer errors = 0, tests_run = 0, k, p;
  logic [19:0] g, e;
  logic [41:0] rows [6] = '{{2'h0, 20'h00003, 20'h00003},
    {2'h2, 20'h3ffff, 20'h3ffff}, {2'h1, 20'h7ff80, 20'h7ff80},
    {2'h3, 20'h001ff, 20'h001ff}, {2'h2, 20'h155a5, 20'h155a5},
    {2'h1, 20'h0037f, 20'h0037f}};
  logic [6:0] pats [3] = '{7'h55, 7'h2a, 7'h7f};
  always #2.5 mclk = ~mclk;
  dsc_host_model hst (.ser_clk(sck), .ser_data(sda), .load_strobe(sle));
  dsc_control_words dut (.mclk(mclk), .reset(reset), .ser_clk(sck),
    .ser_data(sda), .load_strobe(sle), .ref1_div_out(aux[6]),
    .ref2_div_out(aux[5]), .fb1_div_out(aux[4]), .fb2_div_out(aux[3]),
    .lock1_detect(aux[2]), .lock2_detect(aux[1]), .fast_acquire(aux[0]),
    .pump1_pulse_done(pd1), .pump2_pulse_done(pd2),
    .reference_divide_count1(rc1), .reference_divide_count2(rc2),
    .swallow_count1(sw1), .swallow_count2(sw2),
    .binary_feedback_count1(bc1), .binary_feedback_count2(bc2),
    .detector_polarity1(pol1), .detector_polarity2(pol2),
    .pump_current_gain1(gn1), .pump_current_gain2(gn2),
    .pump_hiz_select1(hz1), .pump_hiz_select2(hz2), .prescaler_sel1(ps1),
    .prescaler_sel2(ps2), .synth_powerdown1(pw1), .synth_powerdown2(pw2),
    .op_mode1(om1), .op_mode2(om2), .synth_off1(off1), .synth_off2(off2),
    .multifunction_out_select(sel), .counter_hold1(h1),
    .counter_hold2(h2), .mf_out(mfo), .mf_oe(mfe), .ratio_error(rerr));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [19:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic ld(input logic [1:0] a, input logic [19:0] d);
    hst.send({d, a}, 1'b1);
    repeat (6) @(negedge mclk);
  endtask
  function automatic logic [19:0] obs(input logic [1:0] a);
    case (a)
      2'h0: obs = {2'h0, hz2, gn2, pol2, rc2};
      2'h1: obs = {pw2, ps2, bc2, sw2};
      2'h2: obs = {2'h0, hz1, gn1, pol1, rc1};
      default: obs = {pw1, ps1, bc1, sw1};
    endcase
  endfunction
  // Expected {hold1, hold2, enable, data} of the multi-function pin
  function automatic logic [3:0] expmf(input logic [3:0] c,
                                       input logic [6:0] x);
    logic o;
    case (c)
      4'h1, 4'h9: o = x[5];
      4'h2, 4'ha: o = x[6];
      4'h4: o = x[1];
      4'h5, 4'hd: o = x[3];
      4'h6, 4'he: o = x[4];
      4'h8: o = x[2];
      4'hc: o = x[2] & x[1];
      default: o = 1'b0;
    endcase
    expmf = {c == 4'hb || c == 4'hf, c == 4'h7 || c == 4'hf,
             c != 4'h3 || x[0], o};
  endfunction
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    errors++;
    end_of_test;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    repeat (3) @(negedge mclk);
    chk({mfe, sel, rc1}, {1'b1, 4'h0, 15'h0000}, "reset values");
    $display("test reset done");
    for (k = 0; k < 6; k++) begin
      ld(rows[k][41:40], rows[k][39:20]);
      g = obs(rows[k][41:40]);
      e = rows[k][19:0];
      chk(g, e, "row");
    end
    $display("test rows done");
    hst.send({20'h00fff, 2'h0}, 1'b0);
    repeat (6) @(negedge mclk);
    chk(obs(2'h0), 20'h00003, "shift without strobe");
    ld(2'h0, 20'h00002);
    chk(rerr, 1'b1, "ratio two flagged");
    ld(2'h0, 20'h00003);
    ld(2'h3, 20'h00100);
    chk(rerr, 1'b1, "binary two flagged");
    ld(2'h3, 20'h001ff);
    chk(rerr, 1'b0, "minimum ratios accepted");
    $display("test ratios done");
    for (k = 0; k < 16; k++) begin
      ld(2'h2, {k[1], k[3], 18'h00003});
      ld(2'h0, {k[0], k[2], 18'h00003});
      chk(sel, k[3:0], "select assembly");
      for (p = 0; p < 3; p++) begin
        aux = pats[p];
        repeat (4) @(negedge mclk);
        g = expmf(k[3:0], aux);
        chk({h1, h2, mfe, mfo}, g, "mf");
      end
    end
    $display("test select codes done");
    ld(2'h2, 20'h00003);
    ld(2'h0, 20'h00003);
    ld(2'h1, 20'h80180);
    chk({om2, off2}, {2'h2, 1'b0}, "sync powerdown waits");
    pd2 = 1'b1;
    @(negedge mclk) pd2 = 1'b0;
    repeat (3) @(negedge mclk);
    chk(off2, 1'b1, "sync powerdown after pulse");
    ld(2'h1, 20'h00180);
    chk(off2, 1'b0, "powered up again");
    ld(2'h2, 20'h20003);
    chk({om1, off1}, {2'h1, 1'b0}, "hiz stays active");
    ld(2'h3, 20'h80180);
    chk({om1, off1}, {2'h3, 1'b1}, "async powerdown");
    ld(2'h3, 20'h00180);
    ld(2'h2, 20'h00003);
    ld(2'h3, 20'h80180);
    chk({om1, off1}, {2'h2, 1'b0}, "first sync waits");
    pd1 = 1'b1;
    @(negedge mclk) pd1 = 1'b0;
    repeat (3) @(negedge mclk);
    chk(off1, 1'b1, "first sync after pulse");
    $display("test powerdown done");
    reset = 1'b1;
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    repeat (2) @(negedge mclk);
    chk({off1, sel, rc1}, {1'b0, 4'h0, 15'h0000}, "mid-run reset");
    $display("test mid-run reset done");
    end_of_test;
  end
endmodule
`default_nettype wire
